// ===== acpc_pkg.sv
/*
  Package for the converter clock, power and calibration control block.
  Assumes a single 200 MHz system clock and a plain register port.
*/
package acpc_pkg;
  localparam logic [31:0] CONVERTER_CONTROL_ADDR = 32'h4001C000;
  localparam int          DIV_LSB                = 0;
  localparam int          DIV_MSB                = 7;
  localparam int          SRC_BIT                = 8;
  localparam int          APD_BIT                = 10;
  localparam int          CAL_BIT                = 30;
  localparam logic [31:0] CTRL_RESET             = 32'h00000000;
  localparam logic [31:0] CTRL_WMASK             = 32'h400005FF; // divider, source, power-down, calibrate
  localparam int          BYPASS_DELAY_CLKS      = 2;            // system clocks, trigger to sample
  localparam int          WAKE_CONV_CLKS         = 15;           // converter clocks of start-up delay
  localparam int          CONV_CONV_CLKS         = 25;           // converter clocks per conversion
  localparam int          CAL_CONV_CLKS          = 64;           // converter clocks per calibration
  localparam logic [7:0]  CNT_ONE                = 8'h01;

  typedef enum logic [2:0] {ACPC_IDLE, ACPC_WAKE, ACPC_DELAY, ACPC_CONV, ACPC_CAL} acpc_state_e;
endpackage : acpc_pkg

// ===== acpc_ctrl.sv
/*
  Converter control: clock divider, clock source select, trigger launch timing,
  automatic analog power-down and the self-calibration cycle.
  Assumes all inputs synchronous to ref_clk_in; the alternate converter clock
  arrives as an already synchronised tick (alt_clk_tick_in).
*/
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - the converter clock ticks once every divider-plus-one system clocks.
// - bit 8 selects divided system clock (0) or the independent alternate clock (1).
// - in synchronous mode the divided clock restarts at a trigger for deterministic launch.
// - synchronous mode with bypass starts sampling two system clocks after the trigger edge.
// - with auto power-down set the analog part is off when idle and woken by a trigger.
// - auto power-down adds about 15 converter clocks between trigger and sampling.
// - auto power-down never wakes the analog part while system control holds it off.
// - with auto power-down clear the analog part stays powered unless system control holds it off.
// - writing one to bit 30 starts calibration and hardware clears it when done.
// - a conversion takes 25 converter clock periods after sampling begins.
module acpc_ctrl
  import acpc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        trigger_in,
  input  wire logic        sync_bypass_in,
  input  wire logic        pending_in,
  input  wire logic        sysctl_pd_in,
  input  wire logic        alt_clk_tick_in,
  output logic             conv_clk_tick_out,
  output logic             analog_on_out,
  output logic             sample_start_out,
  output logic             conv_done_out,
  output logic             cal_busy_out
);

  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [7:0]  div_cnt;
  logic [7:0]  next_div_cnt;
  logic        tick;
  logic        next_tick;
  logic [7:0]  phase_cnt;
  logic [7:0]  next_phase_cnt;
  acpc_state_e state;
  acpc_state_e next_state;
  logic        trig_q;
  logic        trig_edge;
  logic        sample_start;
  logic        conv_done;
  logic        cal_done;
  logic [31:0] next_rdata;

  // one mapped register: every access path decodes the same address
  function automatic logic hit_ctrl(input logic [31:0] a);
    hit_ctrl = (a == CONVERTER_CONTROL_ADDR);
  endfunction : hit_ctrl

  wire logic [7:0] divider = ctrl[DIV_MSB:DIV_LSB];
  wire logic       alt_src = ctrl[SRC_BIT];
  wire logic       apd     = ctrl[APD_BIT];
  wire logic       cal_go  = wr_in && hit_ctrl(addr_in) && wdata_in[CAL_BIT];
  wire logic       cal_req = cal_go || ctrl[CAL_BIT]; // a start written mid-conversion is held in bit 30 until idle

  // converter clock tick: selects the alternate tick or the divided tick
  function automatic logic conv_tick(input logic alt, input logic alt_t, input logic div_t);
    conv_tick = alt ? alt_t : div_t;
  endfunction : conv_tick

  wire logic cclk = conv_tick(alt_src, alt_clk_tick_in, tick);

  assign trig_edge = trigger_in && !trig_q;

  // control register: software write, hardware clears calibrate
  always_comb begin
    next_ctrl = ctrl;
    if (wr_in && hit_ctrl(addr_in)) begin
      next_ctrl = wdata_in & CTRL_WMASK; // reserved bits stay zero
    end
    if (cal_done) begin
      next_ctrl[CAL_BIT] = 1'b0; // cleared when the cycle ends
    end
  end

  // divider: restarted by a trigger in synchronous mode so launch is deterministic
  always_comb begin
    next_div_cnt = div_cnt + CNT_ONE;
    next_tick    = 1'b0;
    if (state == ACPC_IDLE && trig_edge) begin
      next_div_cnt = '0;
    end else if (div_cnt >= divider) begin
      next_div_cnt = '0;
      next_tick    = 1'b1; // divide by divider plus one
    end
  end

  // sequencer for wake-up, sampling, conversion and calibration
  always_comb begin
    next_state     = state;
    next_phase_cnt = phase_cnt;
    sample_start   = 1'b0;
    conv_done      = 1'b0;
    cal_done       = 1'b0;
    case (state)
      ACPC_IDLE: begin
        next_phase_cnt = '0;
        if (cal_req) begin
          next_state = ACPC_CAL;
        end else if (trig_edge && !sysctl_pd_in) begin // no wake under system power-down
          if (apd) begin
            next_state = ACPC_WAKE;
          end else if (!alt_src && sync_bypass_in) begin
            next_state = ACPC_DELAY;
          end else begin
            next_state = ACPC_DELAY;
          end
        end
      end
      ACPC_WAKE: begin
        if (cclk) begin
          next_phase_cnt = phase_cnt + CNT_ONE;
        end
        if (cclk && phase_cnt == 8'(WAKE_CONV_CLKS - 1)) begin // start-up delay
          next_state     = ACPC_CONV;
          next_phase_cnt = '0;
          sample_start   = 1'b1;
        end
      end
      ACPC_DELAY: begin
        // no auto power-down, bypass or not: one more clock here gives sampling two clocks after the edge
        next_phase_cnt = phase_cnt + CNT_ONE;
        if (phase_cnt == 8'(BYPASS_DELAY_CLKS - 2)) begin
          next_state     = ACPC_CONV;
          next_phase_cnt = '0;
          sample_start   = 1'b1;
        end
      end
      ACPC_CONV: begin
        if (cclk) begin
          next_phase_cnt = phase_cnt + CNT_ONE;
        end
        if (cclk && phase_cnt == 8'(CONV_CONV_CLKS - 1)) begin // 25 converter clocks
          conv_done      = 1'b1;
          next_phase_cnt = '0;
          if (pending_in && !sysctl_pd_in) begin
            next_state   = ACPC_CONV; // back to back, stays powered
            sample_start = 1'b1;
          end else begin
            next_state = ACPC_IDLE; // idle if nothing pending or under system power-down; powered down there with auto power-down or system power-down
          end
        end
      end
      ACPC_CAL: begin
        if (cclk) begin
          next_phase_cnt = phase_cnt + CNT_ONE;
        end
        if (cclk && phase_cnt == 8'(CAL_CONV_CLKS - 1)) begin
          cal_done       = 1'b1;
          next_state     = ACPC_IDLE;
          next_phase_cnt = '0;
        end
      end
      default: begin
        next_state = ACPC_IDLE;
      end
    endcase
  end

  // read data: only the defined fields come back
  always_comb begin
    next_rdata = '0;
    if (rd_in && hit_ctrl(addr_in)) begin
      next_rdata = ctrl; // calibrate bit reads one while busy
    end
  end

  // all state registers except the helper tick counter
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl              <= CTRL_RESET;
      div_cnt           <= '0;
      tick              <= 1'b0;
      phase_cnt         <= '0;
      state             <= ACPC_IDLE;
      trig_q            <= 1'b0;
      rdata_out         <= '0;
      sample_start_out  <= 1'b0;
      conv_done_out     <= 1'b0;
      conv_clk_tick_out <= 1'b0;
    end else begin
      ctrl              <= next_ctrl;
      div_cnt           <= next_div_cnt;
      tick              <= next_tick;
      phase_cnt         <= next_phase_cnt;
      state             <= next_state;
      trig_q            <= trigger_in;
      rdata_out         <= next_rdata;
      sample_start_out  <= sample_start;
      conv_done_out     <= conv_done;
      conv_clk_tick_out <= cclk; // source selected by bit 8
    end
  end

  // analog power: always on unless auto power-down, never against system power-down
  assign analog_on_out = !sysctl_pd_in && (!apd || state != ACPC_IDLE);
  assign cal_busy_out  = ctrl[CAL_BIT];

  chk_bypass_two_clocks: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ACPC_IDLE && trig_edge && !sysctl_pd_in && !apd && !cal_req) |-> ##2 sample_start_out)
    else $error("bypass launch not two clocks after trigger");
  chk_power_always_on: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!apd && !sysctl_pd_in) |-> analog_on_out)
    else $error("analog off with auto power-down clear");
  chk_sysctl_no_wake: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    sysctl_pd_in |-> !analog_on_out)
    else $error("analog powered during system power-down");
  chk_apd_idle_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (apd && state == ACPC_IDLE) |-> !analog_on_out)
    else $error("analog on while idle in auto power-down");
  chk_cal_busy_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ACPC_CAL) |-> cal_busy_out)
    else $error("calibrate bit low during calibration");
  chk_cal_clears: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cal_done |=> !cal_busy_out && state == ACPC_IDLE)
    else $error("calibrate bit not cleared at end");
  chk_div_period: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (tick && $stable(divider) && state != ACPC_IDLE && divider == 8'h00) |=> tick)
    else $error("divide by one does not tick every clock");
  chk_reserved_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ctrl & ~CTRL_WMASK) == 32'h00000000)
    else $error("reserved control bits not zero");
  chk_wake_to_sample: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ACPC_WAKE && next_state == ACPC_CONV) |-> cclk && phase_cnt == 8'(WAKE_CONV_CLKS - 1))
    else $error("wake delay not fifteen converter clocks");

  // helper: converter ticks since sampling began, independent of the sequencer counter
  logic [7:0] conv_tick_cnt;
  logic [7:0] next_conv_tick_cnt;

  always_comb begin
    next_conv_tick_cnt = conv_tick_cnt;
    if (sample_start) begin
      next_conv_tick_cnt = '0;
    end else if (state == ACPC_CONV && cclk) begin
      next_conv_tick_cnt = conv_tick_cnt + CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      conv_tick_cnt <= '0;
    end else begin
      conv_tick_cnt <= next_conv_tick_cnt;
    end
  end

  // entry and exit checks of the sequencer, divider restart and tick output
  chk_conv_length: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    conv_done |-> conv_tick_cnt == 8'(CONV_CONV_CLKS - 1))
    else $error("conversion not twenty-five converter clocks");
  chk_div_restart: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ACPC_IDLE && trig_edge) |=> div_cnt == 8'h00 && !tick)
    else $error("divider not restarted by trigger");
  chk_tick_alt: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (alt_src && alt_clk_tick_in) |=> conv_clk_tick_out)
    else $error("alternate tick not passed on");
  chk_tick_div: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!alt_src && tick) |=> conv_clk_tick_out)
    else $error("divided tick not passed on");
  chk_apd_wake: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ACPC_IDLE && trig_edge && apd && !sysctl_pd_in && !cal_req) |=> state == ACPC_WAKE)
    else $error("trigger did not wake analog part");
  chk_conv_then_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (conv_done && !pending_in) |=> state == ACPC_IDLE)
    else $error("not idle after last conversion");
  chk_pd_refuse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ACPC_IDLE && sysctl_pd_in && !cal_req) |=> state == ACPC_IDLE)
    else $error("trigger accepted under system power-down");
  chk_cal_starts: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ACPC_IDLE && cal_req) |=> state == ACPC_CAL && cal_busy_out)
    else $error("calibration did not start");
  chk_reset_fields: assert property (@(posedge ref_clk_in)
    rst_in |=> ctrl == CTRL_RESET && state == ACPC_IDLE)
    else $error("control fields not zero after reset");

  // main scenarios worth seeing
  cov_apd_conv:  cover property (@(posedge ref_clk_in) state == ACPC_WAKE ##[1:400] sample_start_out);
  cov_cal_cycle: cover property (@(posedge ref_clk_in) state == ACPC_CAL ##[1:1000] cal_done);
  cov_conv_done: cover property (@(posedge ref_clk_in) conv_done_out);
  cov_back_to_back: cover property (@(posedge ref_clk_in) conv_done && sample_start);
  cov_pd_refused: cover property (@(posedge ref_clk_in) state == ACPC_IDLE && trig_edge && sysctl_pd_in);

endmodule : acpc_ctrl

// ===== acpc_ctrl_tb.sv
/*
  Self-checking bench for the converter clock, power and calibration control.
  Assumes the acpc_ctrl ports and acpc_pkg constants; no partner model needed.
*/
`timescale 1ns/1ps
module adc_clock_power_calibration_ctrl_tb;
  import acpc_pkg::*;
  logic        ref_clk_in, rst_in, wr_in, rd_in, trigger_in, sync_bypass_in;
  logic        pending_in, sysctl_pd_in, alt_clk_tick_in;
  logic [31:0] addr_in, wdata_in, rdata_out;
  logic        conv_clk_tick_out, analog_on_out, sample_start_out, conv_done_out, cal_busy_out;
  logic        on_at_sample;
  int          err_total = 0;
  int          checked = 0;
  int          n, m, gap, c;
  int          alt_period = 16;

  acpc_ctrl u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .trigger_in(trigger_in),
    .sync_bypass_in(sync_bypass_in), .pending_in(pending_in), .sysctl_pd_in(sysctl_pd_in),
    .alt_clk_tick_in(alt_clk_tick_in), .conv_clk_tick_out(conv_clk_tick_out),
    .analog_on_out(analog_on_out), .sample_start_out(sample_start_out),
    .conv_done_out(conv_done_out), .cal_busy_out(cal_busy_out));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // window compare where only an approximate figure is fixed
  task automatic rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : rng

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    wr_in    <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge ref_clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask : rd

  // one trigger pulse; edges to sample start, cycles to done, tick gap
  task automatic fire(output int ns, output int ms, output int g);
    int t;
    ns = 0;
    ms = 0;
    g  = 0;
    t  = 0;
    @(posedge ref_clk_in);
    trigger_in <= 1'b1;
    @(posedge ref_clk_in);
    trigger_in <= 1'b0;
    #1;
    ns = 1; // the edge that takes the trigger counts as the first
    while (!sample_start_out && ns < 200) begin
      @(posedge ref_clk_in);
      #1 ns++;
    end
    on_at_sample = analog_on_out;
    while (!conv_done_out && ms < 800) begin
      @(posedge ref_clk_in);
      #1 ms++;
      if (conv_clk_tick_out) begin
        if (t > 0 && g == 0) g = ms - t;
        t = ms;
      end
    end
  endtask : fire

  // 200 MHz system clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  // alternate converter clock: 12.5 MHz, 500 kHz for calibration; never above 15 MHz
  initial begin
    alt_clk_tick_in = 1'b0;
    forever begin
      repeat (alt_period - 1) @(posedge ref_clk_in);
      alt_clk_tick_in <= 1'b1;
      @(posedge ref_clk_in);
      alt_clk_tick_in <= 1'b0;
    end
  end

  // calibration at 500 kHz dominates: about 25600 cycles, so allow over twice that
  initial begin
    #300000;
    err_total++;
    give_verdict();
  end

  initial begin
    rst_in = 1'b1;
    {wr_in, rd_in, trigger_in, sync_bypass_in, pending_in, sysctl_pd_in} = 6'h00;
    addr_in  = CONVERTER_CONTROL_ADDR;
    wdata_in = 32'h00000000;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(CONVERTER_CONTROL_ADDR, CTRL_RESET);
    rd(CONVERTER_CONTROL_ADDR + 32'h4, 32'h00000000);
    chk(analog_on_out, 32'h1);
    wr(CONVERTER_CONTROL_ADDR, 32'h3FFFFF03);
    rd(CONVERTER_CONTROL_ADDR, 32'h00000503);
    $display("test reset and access done");
    wr(CONVERTER_CONTROL_ADDR, 32'h00000006);
    for (int b = 0; b < 2; b++) begin
      sync_bypass_in <= b[0];
      fire(n, m, gap);
      chk(n, 32'h2);
      chk(gap, 32'h7);
      rng(m, 170, 180);
      chk(analog_on_out, 32'h1);
    end
    wr(CONVERTER_CONTROL_ADDR, 32'h00000106);
    fire(n, m, gap);
    chk(gap, 32'h10);
    rng(m, 380, 405);
    $display("test clock modes done");
    wr(CONVERTER_CONTROL_ADDR, 32'h00000406);
    chk(analog_on_out, 32'h0);
    fire(n, m, gap);
    rng(n, 100, 112);
    chk(on_at_sample, 32'h1);
    @(posedge ref_clk_in);
    #1 chk(analog_on_out, 32'h0);
    sysctl_pd_in <= 1'b1;
    fire(n, m, gap);
    chk(n, 32'd200);
    chk(analog_on_out, 32'h0);
    sysctl_pd_in <= 1'b0;
    $display("test power-down done");
    alt_period = 400;                                       // 500 kHz converter clock
    wr(CONVERTER_CONTROL_ADDR, 32'h40000100);
    rd(CONVERTER_CONTROL_ADDR, 32'h40000100);
    chk(cal_busy_out, 32'h1);
    c = 0;
    // only reads while busy, no write until the cycle ends
    while (cal_busy_out && c < 30000) begin
      @(posedge ref_clk_in);
      #1 c++;
    end
    rng(c, 25190, 25610);
    rd(CONVERTER_CONTROL_ADDR, 32'h00000100);
    $display("test calibration done");
    give_verdict();
  end
endmodule : adc_clock_power_calibration_ctrl_tb
